//--- design/spi_interface_config_regs.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Reset request resets chip and all registers
// [RULE2] Reset request bit clears itself, reads zero
// [RULE3] Host waits 750 ns after reset request
// [RULE4] Streaming address decrements at 0, increments at 1
// [RULE5] Output flag reads 1; reads on output pin
// [RULE6] No three-wire mode; input never driven
// [RULE7] Mode 0 normal, mode 3 full power down
// [RULE8] Maker code fixed 16 bits, writes ignored
// [RULE9] Freeze bit holds address through streaming
// [RULE10] Host writes reset values into reserved fields
// [RULE11] Interface configuration reads 0x30 after reset
// [RULE12] Step after each byte; first byte at command
module spi_interface_config_regs
    import spi_cfg_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'hA5C3  // Arbitrary neutral value
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Serial pins
    input  wire logic sclk,
    input  wire logic cs_b,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdo_oe,
    // Device controls
    output logic       chip_reset,
    output logic [1:0] power_mode,
    output logic       full_power_down
);

    // ****************************************
    // Serial link
    // ****************************************
    spi_frame_if fr ();

    spi_link_shifter u_link (
        .clk    (clk),
        .rst_b  (rst_b),
        .sclk   (sclk),
        .cs_b   (cs_b),
        .sdi    (sdi),
        .sdo    (sdo),
        .sdo_oe (sdo_oe),
        .fr     (fr.link)
    );

    // ****************************************
    // Address stepping
    // ****************************************
    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a,
        input logic              up,
        input logic              frz
    );
        next_addr = frz ? a : (up ? a + ADDR_ONE : a - ADDR_ONE);
    endfunction

    logic [7:0]           ifc_q;
    logic [7:0]           pwr_q;
    logic [7:0]           usr_q;
    logic [ADDR_W-1:0]    addr_q;
    logic [RST_CNT_W-1:0] rst_cnt_q;
    logic                 wr_en;
    logic                 hit_ifc;
    logic                 hit_pwr;
    logic                 hit_usr;
    logic                 hit_mlo;
    logic                 hit_mhi;
    logic                 soft_req;
    logic                 ascend;
    logic                 hold;
    logic [7:0]           ifc_rd;
    logic [7:0]           rd_data;

    // ****************************************
    // Decode
    // ****************************************
    assign hit_ifc  = (addr_q == OFF_IFC_CFG);
    assign hit_pwr  = (addr_q == OFF_PWR_CFG);
    assign hit_usr  = (addr_q == OFF_USR_CFG);
    assign hit_mlo  = (addr_q == OFF_MAKER_LO);
    assign hit_mhi  = (addr_q == OFF_MAKER_HI);
    assign wr_en    = fr.byte_done & ~fr.is_read & ~chip_reset;
    assign soft_req = wr_en & hit_ifc & fr.wdata[IFC_BIT_SOFT];  // [RULE1]
    assign ascend   = ifc_q[IFC_BIT_ASC];
    assign hold     = usr_q[USR_BIT_HOLD];
    assign chip_reset = (rst_cnt_q != RST_CNT_ZERO);

    // Request bit never stored; output flag forced high
    assign ifc_rd = ifc_q | IFC_RO_ONES;  // [RULE2] [RULE5]

    assign rd_data = hit_ifc ? ifc_rd :
                     hit_pwr ? pwr_q :
                     hit_usr ? usr_q :
                     hit_mlo ? MAKER_CODE[7:0] :  // [RULE8]
                     hit_mhi ? MAKER_CODE[15:8] : RD_UNMAPPED;

    assign fr.rd_data    = rd_data;
    assign fr.chip_reset = chip_reset;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ifc_q <= IFC_RESET & IFC_RW_MASK;  // [RULE11]
        end else if (soft_req) begin
            ifc_q <= IFC_RESET & IFC_RW_MASK;  // [RULE1] [RULE2]
        end else if (wr_en && hit_ifc) begin
            ifc_q <= fr.wdata & IFC_RW_MASK;  // [RULE4]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_q <= PWR_RESET;
            usr_q <= USR_RESET;
        end else if (soft_req) begin
            pwr_q <= PWR_RESET;  // [RULE1]
            usr_q <= USR_RESET;
        end else if (wr_en) begin
            if (hit_pwr) pwr_q <= fr.wdata;  // [RULE7]
            if (hit_usr) usr_q <= fr.wdata;  // [RULE9]
        end
    end

    // Reset stretch covering the settle time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt_q <= RST_CNT_ZERO;
        end else if (soft_req) begin
            rst_cnt_q <= SOFT_RESET_CYC;  // [RULE1]
        end else if (chip_reset) begin
            rst_cnt_q <= rst_cnt_q - RST_CNT_ONE;
        end
    end

    // Write and step use the settings held before this byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= ADDR_ZERO;
        end else if (soft_req) begin
            addr_q <= ADDR_ZERO;
        end else if (fr.addr_load) begin
            addr_q <= fr.addr;  // [RULE12]
        end else if (fr.byte_done) begin
            addr_q <= next_addr(addr_q, ascend, hold);  // [RULE4] [RULE9] [RULE12]
        end
    end

    // ****************************************
    // Power state
    // ****************************************
    assign power_mode      = pwr_q[1:0];
    assign full_power_down = (power_mode == MODE_PD);  // [RULE7]

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_SOFT_RESET_VALUES: assert property (  // [RULE1]
        soft_req |=> chip_reset && rst_cnt_q == SOFT_RESET_CYC
                     && ifc_rd == IFC_RESET && pwr_q == PWR_RESET && usr_q == USR_RESET)
        else $error("soft reset did not restore registers");

    AST_SOFT_SELF_CLEAR: assert property (  // [RULE2]
        soft_req |=> !ifc_rd[IFC_BIT_SOFT] ##1 !ifc_rd[IFC_BIT_SOFT])
        else $error("reset request bit did not clear");

    AST_SOFT_LENGTH: assert property (  // [RULE1]
        soft_req |=> chip_reset [*8] ##86 (chip_reset && rst_cnt_q == RST_CNT_ONE) ##1 !chip_reset)
        else $error("reset stretch has wrong length");

    AST_ASCEND_STEP: assert property (  // [RULE4]
        fr.byte_done && !fr.addr_load && !soft_req && !hold && ascend
        |=> addr_q == $past(addr_q) + ADDR_ONE)
        else $error("address did not increment");

    AST_DESCEND_STEP: assert property (  // [RULE4]
        fr.byte_done && !fr.addr_load && !soft_req && !hold && !ascend
        |=> addr_q == $past(addr_q) - ADDR_ONE)
        else $error("address did not decrement");

    AST_FLAG_READS_ONE: assert property (  // [RULE5]
        hit_ifc |-> rd_data[IFC_BIT_FLAG])
        else $error("output flag read as zero");

    AST_POWER_DOWN: assert property (  // [RULE7]
        wr_en && hit_pwr && !soft_req && fr.wdata[1:0] == MODE_PD
        |=> full_power_down ##1 (full_power_down || $past(wr_en)))
        else $error("power down not entered");

    AST_MAKER_FIXED: assert property (  // [RULE8]
        (hit_mlo || hit_mhi) && $stable(addr_q)
        |-> rd_data == (hit_mlo ? MAKER_CODE[7:0] : MAKER_CODE[15:8]))
        else $error("maker code read wrong");

    AST_HOLD_ADDR: assert property (  // [RULE9]
        fr.byte_done && !fr.addr_load && !soft_req && hold |=> $stable(addr_q))
        else $error("frozen address moved");

    AST_RESET_VALUE: assert property (  // [RULE11]
        $fell(chip_reset) |-> ifc_rd == IFC_RESET && !full_power_down)
        else $error("configuration not at reset value");

    AST_FIRST_BYTE: assert property (  // [RULE12]
        fr.addr_load && !soft_req |=> addr_q == $past(fr.addr))
        else $error("first byte not at command address");

    COV_SOFT_RESET: cover property (soft_req ##1 chip_reset);
    COV_READ_STREAM: cover property (fr.byte_done && fr.is_read ##[1:200] fr.byte_done && fr.is_read);
    COV_HOLD_WRITE: cover property (wr_en && hold ##[1:200] wr_en && hold);

endmodule

//--- design/spi_link_shifter.sv
`timescale 1ns/1ps
module spi_link_shifter
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Serial pins
    input  wire logic sclk,
    input  wire logic cs_b,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdo_oe,
    // Register side
    spi_frame_if.link fr
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0]  s1_q;
    logic [2:0]  s2_q;
    logic [2:0]  s3_q;
    logic [2:0]  pin_q;
    logic [2:0]  pin_d;
    link_state_e state_q;
    link_state_e state_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic [15:0] hdr_q;
    logic [7:0]  rx_q;
    logic [7:0]  tx_q;
    logic [7:0]  wdata_q;
    logic        addr_load_q;
    logic        byte_done_q;
    logic        load_q;
    logic        sdo_q;
    logic        oe_q;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic        hdr_end;
    logic        byte_end;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q  <= PIN_IDLE;
            s2_q  <= PIN_IDLE;
            s3_q  <= PIN_IDLE;
            pin_q <= PIN_IDLE;
        end else begin
            s1_q  <= {cs_b, sclk, sdi};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    // Change accepted once stages two and three agree
    assign pin_d    = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    assign cs_fall  = pin_q[PIN_CS] & ~pin_d[PIN_CS];
    assign cs_rise  = ~pin_q[PIN_CS] & pin_d[PIN_CS];
    assign sck_rise = ~pin_q[PIN_SCK] & pin_d[PIN_SCK];
    assign sck_fall = pin_q[PIN_SCK] & ~pin_d[PIN_SCK];
    assign hdr_end  = (state_q == ST_HEADER) & sck_rise & (cnt_q == HDR_LAST);
    assign byte_end = (state_q == ST_DATA) & sck_rise & (cnt_q == BYTE_LAST);

    // ****************************************
    // Frame sequencing
    // ****************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (cs_fall) state_d = ST_HEADER;
            ST_HEADER: if (hdr_end) state_d = ST_DATA;
            ST_DATA:   state_d = ST_DATA;
            default:   state_d = ST_IDLE;
        endcase
        if (cs_rise || fr.chip_reset) state_d = ST_IDLE;
    end

    assign cnt_d = (state_d != state_q || byte_end) ? CNT_ZERO :
                   (sck_rise && state_q != ST_IDLE) ? cnt_q + CNT_ONE : cnt_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ****************************************
    // Receive path
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_q <= 16'h0000;
            rx_q  <= 8'h00;
        end else if (sck_rise && state_q == ST_HEADER) begin
            hdr_q <= {hdr_q[14:0], pin_q[PIN_SDI]};
        end else if (sck_rise && state_q == ST_DATA) begin
            rx_q  <= {rx_q[6:0], pin_q[PIN_SDI]};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_q     <= 8'h00;
            addr_load_q <= 1'b0;
            byte_done_q <= 1'b0;
            load_q      <= 1'b0;
        end else begin
            if (byte_end) wdata_q <= {rx_q[6:0], pin_q[PIN_SDI]};
            addr_load_q <= hdr_end & ~fr.chip_reset;
            byte_done_q <= byte_end & ~fr.chip_reset;
            load_q      <= addr_load_q | byte_done_q;
        end
    end

    // ****************************************
    // Transmit path, dedicated output only
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_q  <= 8'h00;
            sdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            if (load_q) tx_q <= fr.rd_data;
            else if (sck_fall && state_q == ST_DATA) tx_q <= {tx_q[6:0], 1'b0};
            if (sck_fall && state_q == ST_DATA) sdo_q <= tx_q[7];
            oe_q <= (state_q == ST_DATA) & hdr_q[HDR_BIT_READ];  // [RULE5] [RULE6]
        end
    end

    assign sdo          = sdo_q;
    assign sdo_oe       = oe_q;
    assign fr.addr      = hdr_q[ADDR_W-1:0];
    assign fr.is_read   = hdr_q[HDR_BIT_READ];
    assign fr.wdata     = wdata_q;
    assign fr.addr_load = addr_load_q;
    assign fr.byte_done = byte_done_q;

    AST_OE_READ_ONLY: assert property (@(posedge clk) disable iff (!rst_b)  // [RULE6]
        sdo_oe |-> $past(state_q == ST_DATA) && fr.is_read)
        else $error("output enabled outside a read data phase");

endmodule

//--- shared/spi_cfg_pkg.sv
package spi_cfg_pkg;

    // ****************************************
    // Serial frame layout
    // ****************************************
    localparam int unsigned ADDR_W       = 15;
    localparam int unsigned HDR_BIT_READ = 15;
    localparam logic [3:0]  HDR_LAST     = 4'hF;
    localparam logic [3:0]  BYTE_LAST    = 4'h7;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_ONE      = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 15'h0001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;

    // Pin vector positions and idle levels
    localparam int unsigned PIN_CS   = 2;
    localparam int unsigned PIN_SCK  = 1;
    localparam int unsigned PIN_SDI  = 0;
    localparam logic [2:0]  PIN_IDLE = 3'h4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_IFC_CFG  = 15'h0000;
    localparam logic [ADDR_W-1:0] OFF_PWR_CFG  = 15'h0002;
    localparam logic [ADDR_W-1:0] OFF_MAKER_LO = 15'h000C;
    localparam logic [ADDR_W-1:0] OFF_MAKER_HI = 15'h000D;
    localparam logic [ADDR_W-1:0] OFF_USR_CFG  = 15'h0010;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned IFC_BIT_SOFT  = 7;
    localparam int unsigned IFC_BIT_ASC   = 5;
    localparam int unsigned IFC_BIT_FLAG  = 4;
    localparam logic [7:0]  IFC_RESET     = 8'h30;
    localparam logic [7:0]  IFC_RW_MASK   = 8'h6F;
    localparam logic [7:0]  IFC_RO_ONES   = 8'h10;
    localparam logic [7:0]  PWR_RESET     = 8'h00;
    localparam logic [7:0]  USR_RESET     = 8'h00;
    localparam int unsigned USR_BIT_HOLD  = 0;
    localparam logic [1:0]  MODE_NORMAL   = 2'h0;
    localparam logic [1:0]  MODE_PD       = 2'h3;
    localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned SOFT_RESET_NS  = 750;
    localparam int unsigned RST_CNT_W      = 7;
    localparam logic [RST_CNT_W-1:0] SOFT_RESET_CYC =
        RST_CNT_W'((SOFT_RESET_NS * CLK_MHZ + 999) / 1000);
    localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 7'h00;
    localparam logic [RST_CNT_W-1:0] RST_CNT_ONE  = 7'h01;

    // Link states, Gray along idle -> header -> data
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HEADER = 2'b01,
        ST_DATA   = 2'b11
    } link_state_e;

endpackage

//--- shared/spi_frame_if.sv
`timescale 1ns/1ps
interface spi_frame_if
    import spi_cfg_pkg::*;
();
    logic              addr_load;
    logic [ADDR_W-1:0] addr;
    logic              byte_done;
    logic              is_read;
    logic [7:0]        wdata;
    logic [7:0]        rd_data;
    logic              chip_reset;

    modport link (
        output addr_load, addr, byte_done, is_read, wdata,
        input  rd_data, chip_reset
    );
    modport regs (
        input  addr_load, addr, byte_done, is_read, wdata,
        output rd_data, chip_reset
    );
endinterface

//--- tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sclk,
    output logic      cs_b,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    localparam int HALF = 8;
    logic busy = 1'b0;

    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        sdi  = 1'b0;
    end

    // Idle data line toggles so a stale level never looks valid
    always @(posedge clk) begin
        if (!busy) begin
            sdi <= #1 ~sdi;
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One sclk pulse, sampling the output pin on the rise
    task automatic pulse(output logic bit_in);
        wait_clk(HALF);
        sclk = 1'b1;
        bit_in = sdo;
        wait_clk(HALF);
        sclk = 1'b0;
    endtask

    // One frame: header then n bytes, MSB first
    task automatic xfer(input logic [15:0] hdr, input int n, input logic [7:0] wd [8],
                        output logic [7:0] rd [8], output logic oe_ok);
        logic bt;
        wait_clk(1);
        busy = 1'b1;
        cs_b = 1'b0;
        oe_ok = 1'b1;
        wait_clk(HALF);
        for (int b = 0; b < 16; b++) begin
            sdi = hdr[15-b];
            pulse(bt);
        end
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j < 8; j++) begin
                sdi = wd[i][7-j];
                pulse(bt);
                rd[i] = {rd[i][6:0], bt};
                oe_ok = oe_ok & (sdo_oe === hdr[15]);
            end
        end
        wait_clk(HALF);
        cs_b = 1'b1;
        busy = 1'b0;
        wait_clk(HALF);
    endtask
endmodule

//--- tb/spi_interface_config_regs_tb.sv
`timescale 1ns/1ps
`define CHECK(got, exp, msg) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("MISMATCH t=%0t %s", $time, msg); \
        end \
    end

module spi_interface_config_regs_tb;
    import spi_cfg_pkg::*;

    localparam logic [15:0] MAKER = 16'h5A3C;  // Arbitrary value
    localparam int          LIMIT = 50000;

    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 sclk;
    logic                 cs_b;
    logic                 sdi;
    logic                 sdo;
    logic                 sdo_oe;
    logic                 chip_reset;
    logic [1:0]           power_mode;
    logic                 full_power_down;
    logic [7:0]           wd [8];
    logic [7:0]           rd [8];
    logic                 oe_ok;
    logic [RST_CNT_W-1:0] hi_cnt = 7'h00;
    int                   fails = 0;
    int                   compares = 0;
    int                   cycles = 0;

    spi_interface_config_regs #(.MAKER_CODE(MAKER)) u_spi_interface_config_regs (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .chip_reset(chip_reset), .power_mode(power_mode), .full_power_down(full_power_down));

    spi_host_model u_spi_host_model (
        .clk(clk), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    initial begin
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Monitors and timeout
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (chip_reset === 1'b1) begin
            hi_cnt <= hi_cnt + RST_CNT_ONE;
        end
        if (cycles == LIMIT) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Frame helpers
    // ****************************************
    task automatic wrn(input logic [14:0] a, input int n);
        u_spi_host_model.xfer({1'b0, a}, n, wd, rd, oe_ok);
        `CHECK(oe_ok, 1'b1, "output enabled in write frame")
    endtask

    task automatic wr1(input logic [14:0] a, input logic [7:0] d);
        wd[0] = d;
        wrn(a, 1);
    endtask

    task automatic rdn(input logic [14:0] a, input int n);
        u_spi_host_model.xfer({1'b1, a}, n, wd, rd, oe_ok);
        `CHECK(oe_ok, 1'b1, "output not enabled in read data")
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_values();
        rdn(OFF_IFC_CFG, 3);
        `CHECK(rd[0], IFC_RESET, "config reset value")
        `CHECK(rd[0][IFC_BIT_FLAG], 1'b1, "output flag")
        `CHECK(rd[1], RD_UNMAPPED, "increment to unmapped")
        `CHECK(rd[2], PWR_RESET, "increment to power state")
        rdn(OFF_USR_CFG, 1);
        `CHECK(rd[0], USR_RESET, "user config reset")
        `CHECK(power_mode, MODE_NORMAL, "mode after reset")
    endtask

    task automatic test_maker();
        rdn(OFF_MAKER_LO, 2);
        `CHECK(rd[0], MAKER[7:0], "maker low byte")
        `CHECK(rd[1], MAKER[15:8], "maker high byte")
        wd[0] = ~MAKER[7:0];
        wd[1] = ~MAKER[15:8];
        wrn(OFF_MAKER_LO, 2);
        rdn(OFF_MAKER_LO, 2);
        `CHECK(({rd[1], rd[0]}), MAKER, "maker after write")
    endtask

    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            wr1(OFF_PWR_CFG, {6'h00, 2'(m)});
            `CHECK(power_mode, 2'(m), "mode output")
            `CHECK(full_power_down, (2'(m) == MODE_PD), "power down output")
            rdn(OFF_PWR_CFG, 1);
            `CHECK(rd[0], ({6'h00, 2'(m)}), "mode readback")
        end
        wr1(OFF_PWR_CFG, PWR_RESET);
    endtask

    task automatic test_descend();
        wr1(OFF_IFC_CFG, 8'h10);
        rdn(OFF_IFC_CFG, 1);
        `CHECK(rd[0], 8'h10, "descend readback")
        rdn(OFF_MAKER_HI, 2);
        `CHECK(({rd[0], rd[1]}), MAKER, "descending read")
        wd[0] = 8'h03;
        wd[1] = 8'h00;
        wd[2] = IFC_RESET;
        wrn(OFF_PWR_CFG, 3);
        `CHECK(power_mode, MODE_PD, "first byte at header address")
        rdn(OFF_IFC_CFG, 1);
        `CHECK(rd[0], IFC_RESET, "descending write")
    endtask

    task automatic test_hold();
        wr1(OFF_USR_CFG, 8'h01);
        wd[0] = 8'h01;
        wd[1] = 8'h02;
        wd[2] = 8'h03;
        wrn(OFF_PWR_CFG, 3);
        `CHECK(power_mode, 2'h3, "held write")
        rdn(OFF_USR_CFG, 3);
        `CHECK(({rd[0], rd[1], rd[2]}), 24'h010101, "held read")
    endtask

    task automatic test_soft_reset();
        wr1(OFF_IFC_CFG, 8'hB0);
        `CHECK(chip_reset, 1'b1, "soft reset running")
        repeat (120) @(posedge clk);
        #1;
        `CHECK(hi_cnt, SOFT_RESET_CYC, "soft reset length")
        `CHECK(power_mode, MODE_NORMAL, "mode cleared")
        `CHECK(full_power_down, 1'b0, "power down cleared")
        rdn(OFF_IFC_CFG, 1);
        `CHECK(rd[0], IFC_RESET, "request bit cleared")
        rdn(OFF_USR_CFG, 1);
        `CHECK(rd[0], USR_RESET, "user config cleared")
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (8) @(posedge clk);
        test_reset_values();
        test_maker();
        test_modes();
        test_descend();
        test_hold();
        test_soft_reset();
        complete_run();
    end
endmodule
